// >>> verilog/dcirq_defs.svh
// Purpose: constants of the dual-core interrupt routing and channel block
// Assumes: included by the package and by the design modules
// Notes:   widths, counts and reset values; no logic here
`ifndef DCIRQ_DEFS_SVH
`define DCIRQ_DEFS_SVH

// ----------------------------------------------------------------------
// interrupt sources and request lines
// ----------------------------------------------------------------------
`define DCIRQ_NUM_SRC 174
`define DCIRQ_SRC_IDX_W 8
`define DCIRQ_SEC_LINES 8
`define DCIRQ_LINE_W 3
`define DCIRQ_SWI_NUM 8
`define DCIRQ_SEC_REQ 16
`define DCIRQ_MAIN_PRIO_W 3
`define DCIRQ_SEC_PRIO_W 2
`define DCIRQ_NMI_SEL 4
`define DCIRQ_WAKE_SRC 39

// ----------------------------------------------------------------------
// channels and channel interrupt structures
// ----------------------------------------------------------------------
`define DCIRQ_CH_NUM 16
`define DCIRQ_CH_W 4
`define DCIRQ_CH_DW 32
`define DCIRQ_CORES 2
`define DCIRQ_CORE_MAIN 0
`define DCIRQ_CORE_SEC 1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define DCIRQ_RST_BIT 1'b0
`define DCIRQ_OWNER_MAIN 1'b0
`define DCIRQ_OWNER_SEC 1'b1

`endif

// >>> verilog/dcirq_pkg.sv
// Purpose: shared types of the dual-core interrupt routing block
// Assumes: dcirq_defs.svh on the include path
// Notes:   the state struct holds every flip-flop of the top module
`default_nettype none
`include "dcirq_defs.svh"
package dcirq_pkg;

  // ----------
  // register state of the top module
  // ----------
  typedef logic [`DCIRQ_CH_DW-1:0] dcirq_word_t;

  typedef struct packed {
    logic [`DCIRQ_NUM_SRC-1:0] main_irq;
    logic [`DCIRQ_SEC_LINES-1:0] sec_irq;
    logic [`DCIRQ_SWI_NUM-1:0] swi;
    logic main_nmi;
    logic sec_nmi;
    logic call_pend;
    logic dbg_s1;
    logic dbg_s2;
    logic dbg_s3;
    logic main_wake;
    logic sec_wake;
    logic [`DCIRQ_CH_NUM-1:0] lock;
    logic [`DCIRQ_CH_NUM-1:0] owner;
    logic [`DCIRQ_CH_NUM-1:0] ntf;
    logic [`DCIRQ_CH_NUM-1:0] rel;
    logic [`DCIRQ_CH_NUM-1:0][`DCIRQ_CH_DW-1:0] data;
    logic [`DCIRQ_CORES-1:0] grant;
    logic [`DCIRQ_CORES-1:0] fail;
    logic [`DCIRQ_CORES-1:0][`DCIRQ_CH_DW-1:0] rdata;
    logic [`DCIRQ_CORES-1:0] chan_irq;
  } dcirq_state_s;

  // state of the priority picker
  typedef struct packed {
    logic valid;
    logic [`DCIRQ_SRC_IDX_W-1:0] idx;
    logic [`DCIRQ_MAIN_PRIO_W-1:0] level;
  } dcirq_pick_s;

endpackage
`default_nettype wire

// >>> verilog/dcirq_prio_pick.sv
// Purpose: nested vectored controller front end, picks the most urgent request
// Assumes: lower level value is more urgent, ties go to the lower index
// Notes:   one cycle of latency, outputs come from flip-flops
`timescale 1ns/1ps
`default_nettype none
`include "dcirq_defs.svh"
module dcirq_prio_pick
  import dcirq_pkg::*;
#(
  parameter int NUM = `DCIRQ_NUM_SRC,
  parameter int PW = `DCIRQ_MAIN_PRIO_W
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // pending requests and their levels
  input wire logic [NUM-1:0] req_in,
  input wire logic [NUM-1:0][PW-1:0] prio_in,
  // most urgent pending request
  output logic valid_out,
  output logic [`DCIRQ_SRC_IDX_W-1:0] idx_out,
  output logic [PW-1:0] level_out
);

  dcirq_pick_s st_r;
  dcirq_pick_s st_nxt;

  // ----------
  // search
  // ----------
  // walk downward so that an equal level at a lower index replaces the hit
  always_comb begin
    st_nxt = '0;
    for (int i = NUM - 1; i >= 0; i--) begin
      if (req_in[i] && (!st_nxt.valid ||
          prio_in[i] <= st_nxt.level[PW-1:0])) begin
        st_nxt.valid = 1'b1;
        st_nxt.idx = i[`DCIRQ_SRC_IDX_W-1:0];
        st_nxt.level = '0;
        st_nxt.level[PW-1:0] = prio_in[i];
      end
    end
  end

  // state register
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign valid_out = st_r.valid;
  assign idx_out = st_r.idx;
  assign level_out = st_r.level[PW-1:0];

endmodule // dcirq_prio_pick
`default_nettype wire

// >>> verilog/dcirq_route.sv
// Purpose: interrupt routing, wakeup and channel/lock unit for two processors
// Assumes: sources and core requests come from logic on mclk_in
// Notes:   all configuration arrives on ports; one debug pin is synchronised
// How it works
// - 174 sources map one-to-one to main lines
// - configurable mux steers sources onto eight secondary lines
// - eight software-only secondary interrupts
// - per-interrupt priority: eight main, four secondary levels
// - up to four selected sources per NMI
// - only 39 sources can wake from Deep Sleep
// - per-core vectored controller and wakeup controller
// - sixteen data channels, each with a lock
// - sixteen channel interrupt structures for notify/release
// - system call request asserts secondary NMI
`timescale 1ns/1ps
`default_nettype none
`include "dcirq_defs.svh"
module dcirq_route
  import dcirq_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // interrupt sources
  input wire logic [`DCIRQ_NUM_SRC-1:0] src_in,
  // main processor request lines and controller
  output logic [`DCIRQ_NUM_SRC-1:0] main_irq_out,
  input wire logic [`DCIRQ_NUM_SRC-1:0] main_en_in,
  input wire logic [`DCIRQ_NUM_SRC-1:0][`DCIRQ_MAIN_PRIO_W-1:0] main_prio_in,
  output logic main_act_valid_out,
  output logic [`DCIRQ_SRC_IDX_W-1:0] main_act_idx_out,
  output logic [`DCIRQ_MAIN_PRIO_W-1:0] main_act_level_out,
  // secondary processor mux, software interrupts and controller
  input wire logic [`DCIRQ_NUM_SRC-1:0] sec_map_en_in,
  input wire logic [`DCIRQ_NUM_SRC-1:0][`DCIRQ_LINE_W-1:0] sec_map_line_in,
  output logic [`DCIRQ_SEC_LINES-1:0] sec_irq_out,
  input wire logic [`DCIRQ_SWI_NUM-1:0] sec_swi_set_in,
  input wire logic [`DCIRQ_SWI_NUM-1:0] sec_swi_clr_in,
  output logic [`DCIRQ_SWI_NUM-1:0] sec_swi_out,
  input wire logic [`DCIRQ_SEC_REQ-1:0] sec_en_in,
  input wire logic [`DCIRQ_SEC_REQ-1:0][`DCIRQ_SEC_PRIO_W-1:0] sec_prio_in,
  output logic sec_act_valid_out,
  output logic [`DCIRQ_SRC_IDX_W-1:0] sec_act_idx_out,
  output logic [`DCIRQ_SEC_PRIO_W-1:0] sec_act_level_out,
  // non-maskable selection
  input wire logic [`DCIRQ_NMI_SEL-1:0] main_nmi_en_in,
  input wire logic [`DCIRQ_NMI_SEL-1:0][`DCIRQ_SRC_IDX_W-1:0] main_nmi_sel_in,
  input wire logic [`DCIRQ_NMI_SEL-1:0] sec_nmi_en_in,
  input wire logic [`DCIRQ_NMI_SEL-1:0][`DCIRQ_SRC_IDX_W-1:0] sec_nmi_sel_in,
  output logic main_nmi_out,
  output logic sec_nmi_out,
  // system function requests
  input wire logic call_main_in,
  input wire logic call_sec_in,
  input wire logic call_dbg_in,
  input wire logic call_ack_in,
  output logic call_pend_out,
  // deep sleep wakeup
  input wire logic main_sleep_in,
  input wire logic sec_sleep_in,
  input wire logic [`DCIRQ_WAKE_SRC-1:0] main_wake_en_in,
  input wire logic [`DCIRQ_WAKE_SRC-1:0] sec_wake_en_in,
  output logic main_wake_out,
  output logic sec_wake_out,
  // main processor channel port
  input wire logic [`DCIRQ_CH_W-1:0] m_chan_idx_in,
  input wire logic m_chan_acq_in,
  input wire logic m_chan_rel_in,
  input wire logic m_chan_wr_in,
  input wire logic m_chan_ntf_in,
  input wire logic [`DCIRQ_CH_DW-1:0] m_chan_wdata_in,
  input wire logic [`DCIRQ_CH_NUM-1:0] m_intr_mask_in,
  input wire logic [`DCIRQ_CH_NUM-1:0] m_intr_clr_in,
  output logic m_chan_grant_out,
  output logic m_chan_fail_out,
  output logic [`DCIRQ_CH_DW-1:0] m_chan_rdata_out,
  output logic m_chan_irq_out,
  // secondary processor channel port
  input wire logic [`DCIRQ_CH_W-1:0] s_chan_idx_in,
  input wire logic s_chan_acq_in,
  input wire logic s_chan_rel_in,
  input wire logic s_chan_wr_in,
  input wire logic s_chan_ntf_in,
  input wire logic [`DCIRQ_CH_DW-1:0] s_chan_wdata_in,
  input wire logic [`DCIRQ_CH_NUM-1:0] s_intr_mask_in,
  input wire logic [`DCIRQ_CH_NUM-1:0] s_intr_clr_in,
  output logic s_chan_grant_out,
  output logic s_chan_fail_out,
  output logic [`DCIRQ_CH_DW-1:0] s_chan_rdata_out,
  output logic s_chan_irq_out,
  // channel status
  output logic [`DCIRQ_CH_NUM-1:0] chan_lock_out,
  output logic [`DCIRQ_CH_NUM-1:0] chan_owner_out,
  output logic [`DCIRQ_CH_NUM-1:0] chan_ntf_out,
  output logic [`DCIRQ_CH_NUM-1:0] chan_rel_out
);

  // ----------
  // helpers
  // ----------
  // out-of-range selections read as an idle source instead of wrapping
  function automatic logic src_pick(input logic [`DCIRQ_NUM_SRC-1:0] s,
                                    input logic [`DCIRQ_SRC_IDX_W-1:0] sel);
    src_pick = (sel < `DCIRQ_NUM_SRC) ? s[sel] : 1'b0;
  endfunction

  // any enabled selector whose source is active
  function automatic logic nmi_or(input logic [`DCIRQ_NUM_SRC-1:0] s,
      input logic [`DCIRQ_NMI_SEL-1:0] en,
      input logic [`DCIRQ_NMI_SEL-1:0][`DCIRQ_SRC_IDX_W-1:0] sel);
    nmi_or = 1'b0;
    for (int k = 0; k < `DCIRQ_NMI_SEL; k++) begin
      nmi_or = nmi_or | (en[k] & src_pick(s, sel[k]));
    end
  endfunction

  dcirq_state_s st_r;
  dcirq_state_s st_nxt;
  logic [`DCIRQ_SEC_LINES-1:0][`DCIRQ_NUM_SRC-1:0] line_hit;
  logic [`DCIRQ_SEC_LINES-1:0] sec_line_raw;
  logic [`DCIRQ_SEC_REQ-1:0] sec_pend;

  // ----------
  // secondary interrupt mux
  // ----------
  // one source feeds at most one line, the one its line number selects, but
  // several sources may share one line, which ORs them together
  genvar gl;
  genvar gs;
  generate
    for (gl = 0; gl < `DCIRQ_SEC_LINES; gl++) begin : g_line
      for (gs = 0; gs < `DCIRQ_NUM_SRC; gs++) begin : g_src
        assign line_hit[gl][gs] = sec_map_en_in[gs] &&
            (sec_map_line_in[gs] == `DCIRQ_LINE_W'(gl));
      end
      assign sec_line_raw[gl] = |(src_in & line_hit[gl]);
    end
  endgenerate

  // ----------
  // next-state logic
  // ----------
  always_comb begin
    logic [`DCIRQ_CORES-1:0][`DCIRQ_CH_W-1:0] idx;
    logic [`DCIRQ_CORES-1:0] acq;
    logic [`DCIRQ_CORES-1:0] rel;
    logic [`DCIRQ_CORES-1:0] wr;
    logic [`DCIRQ_CORES-1:0] ntf;
    logic [`DCIRQ_CORES-1:0][`DCIRQ_CH_DW-1:0] wdata;
    logic me;
    idx = {s_chan_idx_in, m_chan_idx_in};
    acq = {s_chan_acq_in, m_chan_acq_in};
    rel = {s_chan_rel_in, m_chan_rel_in};
    wr = {s_chan_wr_in, m_chan_wr_in};
    ntf = {s_chan_ntf_in, m_chan_ntf_in};
    wdata = {s_chan_wdata_in, m_chan_wdata_in};
    me = `DCIRQ_OWNER_MAIN;
    st_nxt = st_r;

    // request lines: straight copy, one flop of delay for both cores
    st_nxt.main_irq = src_in;
    st_nxt.sec_irq = sec_line_raw;

    // software-only interrupts, a set in the clear cycle wins
    st_nxt.swi = (st_r.swi & ~sec_swi_clr_in) | sec_swi_set_in;

    // debug pin synchroniser, edge taken between second and third stage
    st_nxt.dbg_s1 = call_dbg_in;
    st_nxt.dbg_s2 = st_r.dbg_s1;
    st_nxt.dbg_s3 = st_r.dbg_s2;

    // system function call: pending until the secondary core acknowledges
    st_nxt.call_pend = (st_r.call_pend & ~call_ack_in) | call_main_in |
        call_sec_in | (st_r.dbg_s2 & ~st_r.dbg_s3);

    // non-maskable lines from up to four selected sources each
    st_nxt.main_nmi = nmi_or(src_in, main_nmi_en_in, main_nmi_sel_in);
    st_nxt.sec_nmi = nmi_or(src_in, sec_nmi_en_in, sec_nmi_sel_in) |
        st_nxt.call_pend;

    // wakeup controllers: only the low capable sources reach them
    st_nxt.main_wake = main_sleep_in &
        (|(src_in[`DCIRQ_WAKE_SRC-1:0] & main_wake_en_in));
    st_nxt.sec_wake = sec_sleep_in &
        (|(src_in[`DCIRQ_WAKE_SRC-1:0] & sec_wake_en_in));

    // channel structures: clears first so that a same-cycle set wins
    st_nxt.ntf = st_r.ntf & ~m_intr_clr_in & ~s_intr_clr_in;
    st_nxt.rel = st_r.rel & ~m_intr_clr_in & ~s_intr_clr_in;
    st_nxt.grant = '0;
    st_nxt.fail = '0;

    // main core handled first: on a tie it takes the lock
    for (int c = 0; c < `DCIRQ_CORES; c++) begin
      me = (c == `DCIRQ_CORE_SEC) ? `DCIRQ_OWNER_SEC : `DCIRQ_OWNER_MAIN;
      if (acq[c]) begin
        if (!st_nxt.lock[idx[c]]) begin
          st_nxt.lock[idx[c]] = 1'b1;
          st_nxt.owner[idx[c]] = me;
          st_nxt.grant[c] = 1'b1;
        end else begin
          st_nxt.fail[c] = 1'b1;
        end
      end
      // data may be written only by the holder of the lock
      if (wr[c] && st_nxt.lock[idx[c]] && st_nxt.owner[idx[c]] == me) begin
        st_nxt.data[idx[c]] = wdata[c];
      end
      // release by a non-holder is ignored
      if (rel[c] && st_nxt.lock[idx[c]] && st_nxt.owner[idx[c]] == me) begin
        st_nxt.lock[idx[c]] = 1'b0;
        st_nxt.rel[idx[c]] = 1'b1;
      end
      if (ntf[c]) begin
        st_nxt.ntf[idx[c]] = 1'b1;
      end
    end

    // read data follows the index each core presents
    st_nxt.rdata[`DCIRQ_CORE_MAIN] = st_r.data[m_chan_idx_in];
    st_nxt.rdata[`DCIRQ_CORE_SEC] = st_r.data[s_chan_idx_in];

    // each core sees only the structures it has unmasked
    st_nxt.chan_irq[`DCIRQ_CORE_MAIN] =
        |((st_r.ntf | st_r.rel) & m_intr_mask_in);
    st_nxt.chan_irq[`DCIRQ_CORE_SEC] =
        |((st_r.ntf | st_r.rel) & s_intr_mask_in);
  end

  // state register
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------
  // nested vectored controllers
  // ----------
  // main core sees every source; secondary sees eight lines plus software
  assign sec_pend = {st_r.swi, st_r.sec_irq} & sec_en_in;

  dcirq_prio_pick #(
    .NUM(`DCIRQ_NUM_SRC),
    .PW(`DCIRQ_MAIN_PRIO_W)
  ) u_main_pick (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .req_in(st_r.main_irq & main_en_in),
    .prio_in(main_prio_in),
    .valid_out(main_act_valid_out),
    .idx_out(main_act_idx_out),
    .level_out(main_act_level_out)
  );

  dcirq_prio_pick #(
    .NUM(`DCIRQ_SEC_REQ),
    .PW(`DCIRQ_SEC_PRIO_W)
  ) u_sec_pick (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .req_in(sec_pend),
    .prio_in(sec_prio_in),
    .valid_out(sec_act_valid_out),
    .idx_out(sec_act_idx_out),
    .level_out(sec_act_level_out)
  );

  // ----------
  // outputs
  // ----------
  assign main_irq_out = st_r.main_irq;
  assign sec_irq_out = st_r.sec_irq;
  assign sec_swi_out = st_r.swi;
  assign main_nmi_out = st_r.main_nmi;
  assign sec_nmi_out = st_r.sec_nmi;
  assign call_pend_out = st_r.call_pend;
  assign main_wake_out = st_r.main_wake;
  assign sec_wake_out = st_r.sec_wake;
  assign m_chan_grant_out = st_r.grant[`DCIRQ_CORE_MAIN];
  assign m_chan_fail_out = st_r.fail[`DCIRQ_CORE_MAIN];
  assign m_chan_rdata_out = st_r.rdata[`DCIRQ_CORE_MAIN];
  assign m_chan_irq_out = st_r.chan_irq[`DCIRQ_CORE_MAIN];
  assign s_chan_grant_out = st_r.grant[`DCIRQ_CORE_SEC];
  assign s_chan_fail_out = st_r.fail[`DCIRQ_CORE_SEC];
  assign s_chan_rdata_out = st_r.rdata[`DCIRQ_CORE_SEC];
  assign s_chan_irq_out = st_r.chan_irq[`DCIRQ_CORE_SEC];
  assign chan_lock_out = st_r.lock;
  assign chan_owner_out = st_r.owner;
  assign chan_ntf_out = st_r.ntf;
  assign chan_rel_out = st_r.rel;

endmodule // dcirq_route
`default_nettype wire

// >>> tb/dcirq_core_bfm.sv
// Purpose: behavioural processor core driving one channel port of the router
// Assumes: the bench launches every channel operation through the op task
// Notes:   an op is a one-cycle pulse raised just after a clock edge
`timescale 1ns/1ps
`default_nettype none
module dcirq_core_bfm (
  // clock
  input wire logic mclk_in,
  // channel request side
  output var logic [3:0] idx_out,
  output var logic acq_out,
  output var logic rel_out,
  output var logic wr_out,
  output var logic ntf_out,
  output var logic [31:0] wdata_out,
  // channel answer side
  input wire logic grant_in,
  input wire logic fail_in
);
  // idle port at time zero
  initial begin
    idx_out = 4'h0;
    {acq_out, rel_out, wr_out, ntf_out} = 4'h0;
    wdata_out = 32'h5A5A_5A5A;
  end

  // k bits: acquire, write, release, notify; index stays for read data;
  // callers keep off reserved indices
  task automatic op(input logic [3:0] idx, input logic [3:0] k, input logic [31:0] d,
                    output logic g, output logic f);
    @(posedge mclk_in);
    #1;
    idx_out = idx;
    {acq_out, wr_out, rel_out, ntf_out} = k;
    wdata_out = d;
    @(posedge mclk_in);
    #1;
    {acq_out, wr_out, rel_out, ntf_out} = 4'h0;
    wdata_out = ~d; // released data line must not keep the last word
    g = grant_in;
    f = fail_in;
  endtask
endmodule // dcirq_core_bfm
`default_nettype wire

// >>> tb/dcirq_route_sva.sv
// Purpose: port-level checker for the routing and channel block
// Assumes: bound to dcirq_route, single clock domain
// Notes:   only relations between ports, no internal state
`timescale 1ns/1ps
`default_nettype none
`include "dcirq_defs.svh"
module dcirq_route_sva
  import dcirq_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // routing
  input wire logic [`DCIRQ_NUM_SRC-1:0] src_in,
  input wire logic [`DCIRQ_NUM_SRC-1:0] main_irq_out,
  input wire logic [`DCIRQ_SWI_NUM-1:0] sec_swi_set_in,
  input wire logic [`DCIRQ_SWI_NUM-1:0] sec_swi_out,
  input wire logic main_sleep_in,
  input wire logic [`DCIRQ_WAKE_SRC-1:0] main_wake_en_in,
  input wire logic main_wake_out,
  // system calls
  input wire logic call_main_in,
  input wire logic call_sec_in,
  input wire logic call_dbg_in,
  input wire logic call_pend_out,
  input wire logic sec_nmi_out,
  // channels
  input wire logic [`DCIRQ_CH_W-1:0] m_chan_idx_in,
  input wire logic m_chan_acq_in,
  input wire logic m_chan_rel_in,
  input wire logic m_chan_grant_out,
  input wire logic m_chan_irq_out,
  input wire logic [`DCIRQ_CH_NUM-1:0] m_intr_mask_in,
  input wire logic [`DCIRQ_CH_NUM-1:0] m_intr_clr_in,
  input wire logic [`DCIRQ_CH_W-1:0] s_chan_idx_in,
  input wire logic s_chan_acq_in,
  input wire logic s_chan_ntf_in,
  input wire logic s_chan_grant_out,
  input wire logic s_chan_fail_out,
  input wire logic [`DCIRQ_CH_NUM-1:0] chan_lock_out,
  input wire logic [`DCIRQ_CH_NUM-1:0] chan_owner_out
);
  // only the low sources may wake
  wire logic wake_cause = main_sleep_in && |(src_in[`DCIRQ_WAKE_SRC-1:0] & main_wake_en_in);

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  // ----------
  // multi-step behaviours
  // ----------
  sequence s_call_req; call_main_in || call_sec_in; endsequence
  sequence s_call_seen; call_pend_out && sec_nmi_out; endsequence
  sequence s_both_take;
    m_chan_acq_in && s_chan_acq_in && m_chan_idx_in == s_chan_idx_in &&
    !chan_lock_out[m_chan_idx_in] && !m_chan_rel_in;
  endsequence
  // notify, then mask kept and no clear
  sequence s_ntf_held;
    s_chan_ntf_in && m_intr_mask_in[s_chan_idx_in] ##1
    m_intr_mask_in[$past(s_chan_idx_in)] && !m_intr_clr_in[$past(s_chan_idx_in)];
  endsequence

  main_map_a: assert property (!$past(sys_rst_in) |-> main_irq_out == $past(src_in))
    else $error("main lines wrong");
  swi_set_a: assert property (|sec_swi_set_in |=>
    (sec_swi_out & $past(sec_swi_set_in)) == $past(sec_swi_set_in))
    else $error("swi not set");
  wake_only_a: assert property (!$past(sys_rst_in) |-> main_wake_out == $past(wake_cause))
    else $error("wake output wrong");
  call_nmi_a: assert property (s_call_req |=> s_call_seen)
    else $error("call not pending");
  dbg_call_a: assert property ($rose(call_dbg_in) |-> ##[3:4] call_pend_out)
    else $error("debug call late");
  lock_race_a: assert property (s_both_take |=>
    m_chan_grant_out && s_chan_fail_out && !s_chan_grant_out)
    else $error("race not won by main");
  busy_fail_a: assert property (s_chan_acq_in && chan_lock_out[s_chan_idx_in] &&
    !(m_chan_rel_in && m_chan_idx_in == s_chan_idx_in) |=> s_chan_fail_out && !s_chan_grant_out)
    else $error("busy lock granted");
  grant_own_a: assert property (m_chan_acq_in && !chan_lock_out[m_chan_idx_in] &&
    !m_chan_rel_in |=> m_chan_grant_out && chan_lock_out[$past(m_chan_idx_in)] &&
    !chan_owner_out[$past(m_chan_idx_in)])
    else $error("free lock refused");
  ntf_irq_a: assert property (s_ntf_held |=> m_chan_irq_out)
    else $error("notify irq missing");
endmodule // dcirq_route_sva

bind dcirq_route dcirq_route_sva u_sva (.*);
`default_nettype wire

// >>> tb/dcirq_route_tb.sv
// Purpose: self-checking bench of the routing and channel block
// Assumes: 250 MHz clock, inputs driven 1 ns after each rising edge
// Notes:   two core models drive the channel ports
`timescale 1ns/1ps
`default_nettype none
`include "dcirq_defs.svh"
module dcirq_route_tb;
  import dcirq_pkg::*;
  logic mclk_in, sys_rst_in, call_main_in, call_sec_in, call_dbg_in, call_ack_in;
  logic main_sleep_in, sec_sleep_in, main_nmi_out, sec_nmi_out, call_pend_out;
  logic main_wake_out, sec_wake_out, main_act_valid_out, sec_act_valid_out;
  logic [`DCIRQ_NUM_SRC-1:0] src_in, main_en_in, sec_map_en_in, main_irq_out;
  logic [`DCIRQ_NUM_SRC-1:0][`DCIRQ_MAIN_PRIO_W-1:0] main_prio_in;
  logic [`DCIRQ_NUM_SRC-1:0][`DCIRQ_LINE_W-1:0] sec_map_line_in;
  logic [7:0] sec_swi_set_in, sec_swi_clr_in, sec_swi_out, sec_irq_out;
  logic [7:0] main_act_idx_out, sec_act_idx_out;
  logic [2:0] main_act_level_out;
  logic [1:0] sec_act_level_out;
  logic [15:0] sec_en_in;
  logic [15:0][1:0] sec_prio_in;
  logic [3:0] main_nmi_en_in, sec_nmi_en_in, m_chan_idx_in, s_chan_idx_in;
  logic [3:0][7:0] main_nmi_sel_in, sec_nmi_sel_in;
  logic [38:0] main_wake_en_in, sec_wake_en_in;
  logic m_chan_acq_in, m_chan_rel_in, m_chan_wr_in, m_chan_ntf_in, m_chan_grant_out;
  logic s_chan_acq_in, s_chan_rel_in, s_chan_wr_in, s_chan_ntf_in, s_chan_grant_out;
  logic m_chan_fail_out, s_chan_fail_out, m_chan_irq_out, s_chan_irq_out;
  logic [31:0] m_chan_wdata_in, s_chan_wdata_in, m_chan_rdata_out, s_chan_rdata_out;
  logic [15:0] m_intr_mask_in, m_intr_clr_in, s_intr_mask_in, s_intr_clr_in;
  logic [15:0] chan_lock_out, chan_owner_out, chan_ntf_out, chan_rel_out;
  int fail_count = 0;
  int total_checks = 0;

  dcirq_route dut (.*);
  dcirq_core_bfm u_main (.mclk_in(mclk_in), .idx_out(m_chan_idx_in), .acq_out(m_chan_acq_in),
    .rel_out(m_chan_rel_in), .wr_out(m_chan_wr_in), .ntf_out(m_chan_ntf_in),
    .wdata_out(m_chan_wdata_in), .grant_in(m_chan_grant_out), .fail_in(m_chan_fail_out));
  dcirq_core_bfm u_sec (.mclk_in(mclk_in), .idx_out(s_chan_idx_in), .acq_out(s_chan_acq_in),
    .rel_out(s_chan_rel_in), .wr_out(s_chan_wr_in), .ntf_out(s_chan_ntf_in),
    .wdata_out(s_chan_wdata_in), .grant_in(s_chan_grant_out), .fail_in(s_chan_fail_out));

  // ----------
  // helpers
  // ----------
  function automatic logic [173:0] oh(input int i);
    return 174'h1 << i;
  endfunction
  task automatic tick;
    @(posedge mclk_in);
    #1;
  endtask
  task automatic chk(input string name, input logic [173:0] seen, input logic [173:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude;
    if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------
  // scenarios
  // ----------
  // level 7 loses to level 5
  task automatic t_main;
    main_en_in = oh(77) | oh(173);
    main_prio_in[77] = 3'h5;
    main_prio_in[173] = 3'h2;
    src_in = oh(3) | oh(77) | oh(173);
    tick();
    chk("main_irq", main_irq_out, oh(3) | oh(77) | oh(173));
    tick();
    chk("main_act", {main_act_valid_out, main_act_idx_out, main_act_level_out}, 12'hD6A);
    main_prio_in[173] = 3'h7;
    repeat (2) tick();
    chk("main_act", {main_act_valid_out, main_act_idx_out, main_act_level_out}, 12'hA6D);
    {src_in, main_en_in} = '0;
  endtask

  // 10 and 100 share line 6; swi 3 is request 11
  task automatic t_sec;
    sec_map_en_in = oh(10) | oh(100) | oh(173);
    sec_map_line_in[10] = 3'h6;
    sec_map_line_in[100] = 3'h6;
    src_in = oh(10) | oh(100) | oh(50);
    tick();
    chk("sec_irq", sec_irq_out, 8'h40);
    src_in = oh(173) | oh(50);
    tick();
    chk("sec_irq", sec_irq_out, 8'h01);
    src_in = oh(10);
    sec_en_in = 16'h0840;
    sec_prio_in[11] = 2'h1;
    sec_prio_in[6] = 2'h3;
    sec_swi_set_in = 8'h08;
    tick();
    sec_swi_set_in = 8'h00;
    repeat (2) tick();
    chk("sec_swi", sec_swi_out, 8'h08);
    chk("sec_act", {sec_act_valid_out, sec_act_idx_out, sec_act_level_out}, 11'h42D);
    sec_swi_clr_in = 8'h08;
    tick();
    sec_swi_clr_in = 8'h00;
    repeat (2) tick();
    chk("sec_act", {sec_act_valid_out, sec_act_idx_out, sec_act_level_out}, 11'h41B);
    {src_in, sec_en_in} = '0;
  endtask

  // selector 200 is out of range
  task automatic t_nmi;
    main_nmi_sel_in = 32'h0096_00C8;
    main_nmi_en_in = 4'h5;
    sec_nmi_sel_in = 32'hAD00_0000;
    sec_nmi_en_in = 4'h8;
    src_in = oh(150) | oh(173);
    tick();
    chk("nmi", {main_nmi_out, sec_nmi_out}, 2'h3);
    main_nmi_en_in = 4'h1;
    src_in = oh(150);
    tick();
    chk("nmi", {main_nmi_out, sec_nmi_out}, 2'h0);
    {main_nmi_en_in, sec_nmi_en_in, src_in} = '0;
  endtask

  // only sources 0..38 may wake
  task automatic t_wake;
    {main_sleep_in, sec_sleep_in} = 2'h3;
    main_wake_en_in = '1;
    sec_wake_en_in = 39'h20;
    for (int i = 0; i < 3; i++) begin
      src_in = oh(i == 0 ? 38 : (i == 1 ? 39 : 5));
      tick();
      chk("wake", {main_wake_out, sec_wake_out}, i == 0 ? 2'h2 : (i == 1 ? 2'h0 : 2'h3));
    end
    main_sleep_in = 1'b0;
    tick();
    chk("wake", {main_wake_out, sec_wake_out}, 2'h1);
    {sec_sleep_in, src_in} = '0;
  endtask

  // each requester raises the nmi until ack
  task automatic t_call;
    for (int i = 0; i < 3; i++) begin
      {call_dbg_in, call_sec_in, call_main_in} = 3'h1 << i;
      tick();
      {call_dbg_in, call_sec_in, call_main_in} = 3'h0;
      repeat (4) tick();
      chk("call", {call_pend_out, sec_nmi_out}, 2'h3);
      call_ack_in = 1'b1;
      tick();
      call_ack_in = 1'b0;
      chk("call", {call_pend_out, sec_nmi_out}, 2'h0);
    end
  endtask

  // race, owner write, refusals, release, notify
  task automatic t_lock;
    logic mg, mf, sg, sf;
    m_intr_mask_in = 16'h0010;
    s_intr_mask_in = 16'h0200;
    fork
      u_main.op(4'h9, 4'h8, 32'h0, mg, mf);
      u_sec.op(4'h9, 4'h8, 32'h0, sg, sf);
    join
    chk("race", {mg, mf, sg, sf}, 4'h9);
    chk("lock", {chan_lock_out[9], chan_owner_out[9]}, 2'h2);
    u_main.op(4'h9, 4'h4, 32'hA5C3_0F1E, mg, mf);
    u_sec.op(4'h9, 4'h4, 32'h1111_1111, sg, sf);
    tick();
    chk("rdata", {m_chan_rdata_out, s_chan_rdata_out}, 64'hA5C3_0F1E_A5C3_0F1E);
    u_sec.op(4'h9, 4'h8, 32'h0, sg, sf);
    chk("busy", {sg, sf}, 2'h1);
    u_main.op(4'h9, 4'h2, 32'h0, mg, mf);
    chk("release", {chan_lock_out[9], chan_rel_out[9]}, 2'h1);
    tick();
    chk("s_irq", s_chan_irq_out, 1'b1);
    s_intr_clr_in = 16'h0200;
    tick();
    s_intr_clr_in = 16'h0000;
    tick();
    chk("s_irq", {chan_rel_out[9], s_chan_irq_out}, 2'h0);
    u_sec.op(4'h4, 4'h1, 32'h0, sg, sf);
    chk("notify", chan_ntf_out[4], 1'b1);
    tick();
    chk("m_irq", m_chan_irq_out, 1'b1);
    u_sec.op(4'h9, 4'h8, 32'h0, sg, sf);
    chk("take", {sg, chan_owner_out[9]}, 2'h3);
  endtask

  // ----------
  // clock, reset, sequence and watchdog
  // ----------
  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end
  initial begin
    sys_rst_in = 1'b1;
    {src_in, main_en_in, sec_map_en_in, main_prio_in, sec_map_line_in} = '0;
    {sec_swi_set_in, sec_swi_clr_in, sec_en_in, sec_prio_in} = '0;
    {main_nmi_en_in, sec_nmi_en_in, main_nmi_sel_in, sec_nmi_sel_in} = '0;
    {call_main_in, call_sec_in, call_dbg_in, call_ack_in, main_sleep_in, sec_sleep_in} = '0;
    {main_wake_en_in, sec_wake_en_in} = '0;
    {m_intr_mask_in, m_intr_clr_in, s_intr_mask_in, s_intr_clr_in} = '0;
    repeat (2) @(posedge mclk_in);
    #1;
    sys_rst_in = 1'b0;
    chk("reset", {chan_lock_out, sec_swi_out, call_pend_out, m_chan_irq_out}, '0);
    t_main();
    t_sec();
    t_nmi();
    t_wake();
    t_call();
    t_lock();
    conclude();
  end
  // run needs about 60 cycles
  initial begin
    repeat (3000) @(posedge mclk_in);
    fail_count++;
    conclude();
  end
endmodule // dcirq_route_tb
`default_nettype wire
